// file: hw/alfd_defines.svh
// Register offsets, field positions, reset values for the FIFO data port
//
// Overview of operation
// - Mic pointer register read-only, resets zero
// - Mic read pointer in bits 19:16
// - Mic write pointer in bits 3:0
// - Stereo write pushes upper half left
// - Stereo write pushes lower half right
// - Stereo read returns left input upper
// - Stereo read returns right input lower
// - Stereo data register read/write, resets zero
// - Mic data returns mono sample low half
// - Software data ports serviced only in programmed I/O mode; link side in any mode but off
`ifndef ALFD_DEFINES_SVH
`define ALFD_DEFINES_SVH

`define ALFD_ADDR_CTRL 32'h5b000000
`define ALFD_ADDR_PCMPTR 32'h5b000010
`define ALFD_ADDR_MICPTR 32'h5b000014
`define ALFD_ADDR_PCMDATA 32'h5b000018
`define ALFD_ADDR_MICDATA 32'h5b00001c
`define ALFD_ADDR_STAT 32'h5b000020

`define ALFD_RESET_WORD 32'h00000000
`define ALFD_MODE_OUT_HI 13
`define ALFD_MODE_OUT_LO 12
`define ALFD_MODE_IN_HI 11
`define ALFD_MODE_IN_LO 10
`define ALFD_MODE_MIC_HI 9
`define ALFD_MODE_MIC_LO 8
`define ALFD_CTRL_MASK 32'h00003f00
`define ALFD_FIFO_DEPTH 16

`endif

// file: hw/alfd_pkg.sv
// Types shared by the FIFO data port
package alfd_pkg;
  typedef enum logic [1:0] {
    ALFD_MODE_OFF = 2'b00,
    ALFD_MODE_PIO = 2'b01,
    ALFD_MODE_DMA = 2'b10,
    ALFD_MODE_RSV = 2'b11
  } alfd_mode_e;
  typedef logic [3:0] alfd_ptr_t;
  typedef logic [15:0] alfd_smp_t;
endpackage

// file: hw/alfd_fifo_port.sv
// Software FIFO access port: pointers, stereo and mono sample FIFOs
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "alfd_defines.svh"

module alfd_fifo_port (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link side: PCM out drain
  input wire logic out_pop,
  output logic [15:0] out_left,
  output logic [15:0] out_right,
  output logic out_empty,
  // Link side: PCM in fill
  input wire logic in_push,
  input wire logic [15:0] in_left,
  input wire logic [15:0] in_right,
  output logic in_full,
  // Link side: mic fill
  input wire logic mic_push,
  input wire logic [15:0] mic_sample,
  output logic mic_full
);

  localparam int DEPTH = `ALFD_FIFO_DEPTH;

  // Storage arrays
  alfd_pkg::alfd_smp_t out_l_mem [DEPTH];
  alfd_pkg::alfd_smp_t out_r_mem [DEPTH];
  alfd_pkg::alfd_smp_t in_l_mem [DEPTH];
  alfd_pkg::alfd_smp_t in_r_mem [DEPTH];
  alfd_pkg::alfd_smp_t mic_mem [DEPTH];

  // Pointers and fill counts (index 0 out, 1 in, 2 mic)
  alfd_pkg::alfd_ptr_t wptr_r [3];
  alfd_pkg::alfd_ptr_t rptr_r [3];
  logic [4:0] cnt_r [3];
  logic [2:0] push;
  logic [2:0] pop;
  logic [2:0] full;
  logic [2:0] empty;

  logic [31:0] ctrl_r;
  logic [2:0] err_r;
  alfd_pkg::alfd_mode_e mode_out;
  alfd_pkg::alfd_mode_e mode_in;
  alfd_pkg::alfd_mode_e mode_mic;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [31:0] rd_nxt;

  assign mode_out = alfd_pkg::alfd_mode_e'(
    ctrl_r[`ALFD_MODE_OUT_HI:`ALFD_MODE_OUT_LO]);
  assign mode_in = alfd_pkg::alfd_mode_e'(
    ctrl_r[`ALFD_MODE_IN_HI:`ALFD_MODE_IN_LO]);
  assign mode_mic = alfd_pkg::alfd_mode_e'(
    ctrl_r[`ALFD_MODE_MIC_HI:`ALFD_MODE_MIC_LO]);

  // Access decode, taken in the setup cycle; answer one cycle later
  assign setup = psel && !penable;
  assign wr_acc = setup && pwrite;
  assign rd_acc = setup && !pwrite;

  // Software side moves data only in programmed I/O mode
  assign push[0] = wr_acc && paddr == `ALFD_ADDR_PCMDATA &&
    mode_out == alfd_pkg::ALFD_MODE_PIO && !full[0];
  assign pop[1] = rd_acc && paddr == `ALFD_ADDR_PCMDATA &&
    mode_in == alfd_pkg::ALFD_MODE_PIO && !empty[1];
  assign pop[2] = rd_acc && paddr == `ALFD_ADDR_MICDATA &&
    mode_mic == alfd_pkg::ALFD_MODE_PIO && !empty[2];
  // Link side moves data in any mode but off
  assign pop[0] = out_pop && !empty[0] &&
    mode_out != alfd_pkg::ALFD_MODE_OFF;
  assign push[1] = in_push && !full[1] &&
    mode_in != alfd_pkg::ALFD_MODE_OFF;
  assign push[2] = mic_push && !full[2] &&
    mode_mic != alfd_pkg::ALFD_MODE_OFF;

  // Pointer and count bookkeeping per FIFO
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ptr
      assign full[g] = cnt_r[g] == 5'h10;
      assign empty[g] = cnt_r[g] == 5'h00;
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
        begin
          wptr_r[g] <= 4'h0;
          rptr_r[g] <= 4'h0;
          cnt_r[g] <= 5'h00;
        end
        else
        begin
          if (push[g])
            wptr_r[g] <= wptr_r[g] + 4'h1;
          if (pop[g])
            rptr_r[g] <= rptr_r[g] + 4'h1;
          if (push[g] && !pop[g])
            cnt_r[g] <= cnt_r[g] + 5'h01;
          else if (pop[g] && !push[g])
            cnt_r[g] <= cnt_r[g] - 5'h01;
        end
      end
    end
  endgenerate

  // Sample storage writes
  always_ff @(posedge sys_clk)
  begin
    if (push[0])
    begin
      out_l_mem[wptr_r[0]] <= pwdata[31:16];
      out_r_mem[wptr_r[0]] <= pwdata[15:0];
    end
    if (push[1])
    begin
      in_l_mem[wptr_r[1]] <= in_left;
      in_r_mem[wptr_r[1]] <= in_right;
    end
    if (push[2])
      mic_mem[wptr_r[2]] <= mic_sample;
  end

  // Control register holding the transfer modes
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ctrl_r <= `ALFD_RESET_WORD;
    else if (wr_acc && paddr == `ALFD_ADDR_CTRL)
      ctrl_r <= pwdata & `ALFD_CTRL_MASK;
  end

  // Sticky access errors: 0 out full or not PIO, 1 in empty or not PIO, 2 mic empty or not PIO
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      err_r <= 3'h0;
    else
    begin
      if (wr_acc && paddr == `ALFD_ADDR_PCMDATA && !push[0])
        err_r[0] <= 1'b1;
      else if (wr_acc && paddr == `ALFD_ADDR_STAT && pwdata[0])
        err_r[0] <= 1'b0;
      if (rd_acc && paddr == `ALFD_ADDR_PCMDATA && !pop[1])
        err_r[1] <= 1'b1;
      else if (wr_acc && paddr == `ALFD_ADDR_STAT && pwdata[1])
        err_r[1] <= 1'b0;
      if (rd_acc && paddr == `ALFD_ADDR_MICDATA && !pop[2])
        err_r[2] <= 1'b1;
      else if (wr_acc && paddr == `ALFD_ADDR_STAT && pwdata[2])
        err_r[2] <= 1'b0;
    end
  end

  // Read data mux
  always_comb
  begin
    rd_nxt = `ALFD_RESET_WORD;
    hit = 1'b1;
    case (paddr)
      `ALFD_ADDR_CTRL: rd_nxt = ctrl_r;
      `ALFD_ADDR_PCMPTR:
        rd_nxt = {4'h0, rptr_r[0], 4'h0, rptr_r[1],
                  4'h0, wptr_r[0], 4'h0, wptr_r[1]};
      `ALFD_ADDR_MICPTR:
        rd_nxt = {12'h000, rptr_r[2], 12'h000, wptr_r[2]};
      `ALFD_ADDR_PCMDATA:
        if (pop[1])
          rd_nxt = {in_l_mem[rptr_r[1]], in_r_mem[rptr_r[1]]};
      `ALFD_ADDR_MICDATA:
        if (pop[2])
          rd_nxt = {16'h0000, mic_mem[rptr_r[2]]};
      `ALFD_ADDR_STAT:
        rd_nxt = {21'h0, full, empty, 2'h0, err_r};
      default: hit = 1'b0;
    endcase
  end

  // APB answer: one wait-free access phase after setup
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      prdata <= `ALFD_RESET_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && (!hit ||
        (pwrite && paddr == `ALFD_ADDR_MICPTR));
      if (rd_acc)
        prdata <= rd_nxt;
      else if (setup)
        prdata <= `ALFD_RESET_WORD;
    end
  end

  // Link-side outputs, registered
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      out_left <= 16'h0000;
      out_right <= 16'h0000;
      out_empty <= 1'b1;
      in_full <= 1'b0;
      mic_full <= 1'b0;
    end
    else
    begin
      if (pop[0])
      begin
        out_left <= out_l_mem[rptr_r[0]];
        out_right <= out_r_mem[rptr_r[0]];
      end
      // Flags follow the count after this edge, not before it
      out_empty <= (cnt_r[0] == 5'h00 && !push[0]) ||
        (cnt_r[0] == 5'h01 && pop[0] && !push[0]);
      in_full <= (cnt_r[1] == 5'h10 && !pop[1]) ||
        (cnt_r[1] == 5'h0f && push[1] && !pop[1]);
      mic_full <= (cnt_r[2] == 5'h10 && !pop[2]) ||
        (cnt_r[2] == 5'h0f && push[2] && !pop[2]);
    end
  end

endmodule

// file: test/alfd_port_sva.sv
// Bus and field checks on the FIFO data port
`timescale 1ns/1ps
module alfd_port_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic out_empty
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Setup cycle, and a read answered
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s;
    pready && !pwrite;
  endsequence
  chk_ready_next: assert property (setup_s |=> pready)
    else $error("no ready");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("lone error");
  chk_err_unmap: assert property (setup_s ##0
    paddr == 32'h5b000024 |=> pslverr && prdata == 0)
    else $error("unmapped ok");
  chk_ptr_ro: assert property (setup_s ##0
    (pwrite && paddr == 32'h5b000014) |=> pslverr)
    else $error("ptr written");
  chk_ptr_rsv: assert property (rd_s ##0 paddr == 32'h5b000014
    |-> prdata[31:20] == 0 && prdata[15:4] == 0)
    else $error("ptr reserved");
  chk_mic_rsv: assert property (rd_s ##0 paddr == 32'h5b00001c
    |-> prdata[31:16] == 0)
    else $error("mic reserved");
  chk_empty_rst: assert property ($rose(nrst) |-> out_empty)
    else $error("not empty");
endmodule

bind alfd_fifo_port alfd_port_sva chk (.sys_clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .out_empty);

// file: test/alfd_link_model.sv
// Codec-side model pushing and popping link samples
`timescale 1ns/1ps
module alfd_link_model (
  input wire logic sys_clk,
  output logic out_pop,
  output logic in_push,
  output logic [15:0] in_left,
  output logic [15:0] in_right,
  output logic mic_push,
  output logic [15:0] mic_sample
);
  initial
  begin
    {out_pop, in_push, mic_push} = 3'h0;
    {in_left, in_right, mic_sample} = 48'h0;
  end
  // One strobe; data scrambled once it drops
  task automatic strobe(input int k, input logic [31:0] d);
    @(posedge sys_clk);
    out_pop <= (k == 0);
    in_push <= (k == 1);
    mic_push <= (k == 2);
    {in_left, in_right} <= d;
    mic_sample <= d[15:0];
    @(posedge sys_clk);
    {out_pop, in_push, mic_push} <= 3'h0;
    {in_left, in_right, mic_sample} <= ~{d, d[15:0]};
    @(posedge sys_clk);
  endtask
endmodule

// file: test/audio_link_fifo_data_port_bench.sv
// Self-checking bench for the FIFO data port
`timescale 1ns/1ps
`include "alfd_defines.svh"
`define CHK(n, e, g) \
  tests_run++; \
  if ((g) !== (e)) \
  begin \
    n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, g); \
  end
module audio_link_fifo_data_port_bench;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic out_pop, out_empty, in_push, in_full, mic_push, mic_full;
  logic [31:0] paddr, pwdata, prdata, rd, w;
  logic [15:0] out_left, out_right, in_left, in_right, mic_sample, s;
  int n_fail = 0;
  int tests_run = 0;
  alfd_fifo_port DUT (.sys_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .out_pop, .out_left,
    .out_right, .out_empty, .in_push, .in_left, .in_right, .in_full,
    .mic_push, .mic_sample, .mic_full);
  alfd_link_model link (.sys_clk, .out_pop, .in_push, .in_left,
    .in_right, .mic_push, .mic_sample);
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Pointer word as software sees it
  function automatic logic [31:0] ptr_word(input logic [3:0] r, wr);
    return {12'h0, r, 12'h0, wr};
  endfunction
  // One APB transfer, waits for the answer
  task automatic apb(input logic wt, input logic [31:0] a, d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wt, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = 68'h0;
    void'($urandom(32'hdedb65bc));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(0, `ALFD_ADDR_MICPTR, 0);
    `CHK("pointers", 32'h0, rd)
    apb(0, `ALFD_ADDR_PCMDATA, 0);
    `CHK("idle pcm", 32'h0, rd)
    apb(0, 32'h5b000024, 0);
    `CHK("unmapped", 1'b1, er)
    apb(1, `ALFD_ADDR_CTRL, 32'h2500);
    apb(1, `ALFD_ADDR_PCMDATA, $urandom);
    `CHK("dma refuse", 1'b1, out_empty)
    $display("test reset done");
    apb(1, `ALFD_ADDR_CTRL, 32'h1500);
    for (int i = 0; i < 17; i++)
    begin
      w = $urandom;
      apb(1, `ALFD_ADDR_PCMDATA, w);
      `CHK("filled", 1'b0, out_empty)
      link.strobe(0, 0);
      `CHK("drained", 1'b1, out_empty)
      `CHK("left", w[31:16], out_left)
      `CHK("right", w[15:0], out_right)
      w = $urandom;
      link.strobe(1, w);
      apb(0, `ALFD_ADDR_PCMDATA, 0);
      `CHK("pcm in", w, rd)
      s = 16'($urandom);
      link.strobe(2, {16'h0, s});
      apb(0, `ALFD_ADDR_MICDATA, 0);
      `CHK("mic", {16'h0, s}, rd)
    end
    // Fill both input FIFOs to the brim, then one mic push too many
    for (int i = 0; i < 16; i++)
    begin
      link.strobe(1, $urandom);
      link.strobe(2, $urandom);
    end
    `CHK("in full", 1'b1, in_full)
    `CHK("mic full", 1'b1, mic_full)
    link.strobe(2, 0);
    apb(1, `ALFD_ADDR_MICPTR, 32'hffffffff);
    `CHK("ptr write", 1'b1, er)
    apb(0, `ALFD_ADDR_MICPTR, 0);
    `CHK("wrap", ptr_word(4'h1, 4'h1), rd)
    $display("test stream done");
    give_verdict;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    give_verdict;
  end
endmodule
